// file: ptsp_top.sv
// Trace status port: status nibble, debug nibble, trace clock and AXI4-Lite registers
// Behaviour
// - Output float input low forces all drivers off, asynchronously.
// - Active boundary scan overrides the float input on every pin enable.
// - Trace clock out runs at trace core rate and times both nibble buses.
// - Debug nibble bus is four bits and carries captured data nibble-wise.
// - Status bus changes only on trace clock timing, reflecting execution state.
// - Codes 0000, 0001, 0011 emitted; reserved 0010 and 0110 are never emitted.
// - Codes 0100, 0101, 0111 for marker/write, branch/sync, exception return.
// - Codes 1000 to 1011 announce one to four data bytes.
// - Codes 1100 to 1111: exception, emulator entry, stopped, halted.
// - Codes 1100 to 1111 are held for several trace cycles.
// - Scan pins share the debug pins; scan enables take the pins.
// - Reset pin low starts reset exception and releases the data bus.
// - Wake pin driven low leaves power-down mode.
//
// Design decisions made here: the register addresses and the AXI4-Lite interface to the registers.
module ptsp_top (
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	input wire logic [31:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [31:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	input wire logic [2:0] test_mode_strap_i,
	input wire logic output_float_n_i,
	input wire logic scan_active_i,
	input wire logic scan_oe_i,
	input wire logic reset_in_n_i,
	input wire logic wake_n_i,
	output logic trace_clock_out_o,
	output logic trace_clock_oe_o,
	output logic [3:0] exec_state_bus_o,
	output logic exec_state_oe_o,
	output logic [3:0] debug_nibble_bus_o,
	output logic debug_nibble_oe_o
);
	ptsp_pkg::ptsp_state_t st_ff;
	ptsp_pkg::ptsp_state_t nxt_st;
	logic [ptsp_pkg::SYNC_W-1:0] pins_sync;
	logic [2:0] strap_s;
	logic reset_in_s;
	logic wake_s;
	logic debug_mode_select_strap;
	logic trace_tick;
	logic pad_ok;
	logic [31:0] ctrl_word;
	logic [31:0] status_word;
	logic [7:0] rd_addr;
	logic wr_fire;

	ptsp_sync2 #(
		.W(ptsp_pkg::SYNC_W)
	) u_sync (
		.ref_clk_i(ref_clk_i),
		.rstn_i(rstn_i),
		.async_i({wake_n_i, reset_in_n_i, test_mode_strap_i, 1'b1}),
		.rst_val_i({1'b1, 1'b1, 3'b001, 1'b1}),
		.sync_o(pins_sync)
	);

	assign strap_s = pins_sync[3:1];
	assign reset_in_s = pins_sync[4];
	assign wake_s = pins_sync[5];
	assign debug_mode_select_strap = strap_s[0];
	// Status changes at the trace clock's falling edge so a probe samples mid-cycle
	assign trace_tick = st_ff.pins.tclk;
	assign rd_addr = s_axi_araddr_i[7:0];
	assign wr_fire = st_ff.aw_held && st_ff.w_held && !st_ff.bvalid;

	assign ctrl_word = {30'h0000_0000, st_ff.pdown, st_ff.enable};
	always_comb begin
		status_word = ptsp_pkg::RST_WORD;
		status_word[ptsp_pkg::STAT_PEND_BIT] = st_ff.pend;
		status_word[ptsp_pkg::STAT_PDOWN_BIT] = st_ff.pdown;
		status_word[ptsp_pkg::STAT_ERR_BIT] = st_ff.err;
		status_word[ptsp_pkg::STAT_DBGMODE_BIT] = debug_mode_select_strap;
		status_word[ptsp_pkg::STAT_STRAPBAD_BIT] = |strap_s[2:1];
		status_word[ptsp_pkg::STAT_CODE_LSB +: 4] = st_ff.pins.code;
	end

	always_comb begin
		logic byte_code;
		logic long_code;
		logic rsvd_code;
		logic ev_wr;
		logic [3:0] new_code;
		byte_code = 1'b0;
		long_code = 1'b0;
		rsvd_code = 1'b0;
		ev_wr = 1'b0;
		new_code = s_axi_wdata_i[3:0];
		nxt_st = st_ff;

		// Register writes
		if (s_axi_awvalid_i && st_ff.awready) begin
			nxt_st.aw_held = 1'b1;
			nxt_st.awaddr = s_axi_awaddr_i[7:0];
		end
		if (s_axi_wvalid_i && st_ff.wready) begin
			nxt_st.w_held = 1'b1;
			nxt_st.wdata = s_axi_wdata_i;
			nxt_st.wstrb = s_axi_wstrb_i;
		end
		new_code = st_ff.wdata[3:0];
		if (wr_fire) begin
			nxt_st.aw_held = 1'b0;
			nxt_st.w_held = 1'b0;
			nxt_st.bvalid = 1'b1;
			case (st_ff.awaddr)
				ptsp_pkg::CTRL_OFF: begin
					if (st_ff.wstrb[0]) begin
						nxt_st.enable = st_ff.wdata[ptsp_pkg::CTRL_EN_BIT];
						nxt_st.pdown = st_ff.wdata[ptsp_pkg::CTRL_PDOWN_BIT];
					end
				end
				ptsp_pkg::DATA_OFF: begin
					for (int b = 0; b < 4; b++) begin
						if (st_ff.wstrb[b]) begin
							nxt_st.pend_data[8*b +: 8] = st_ff.wdata[8*b +: 8];
						end
					end
				end
				ptsp_pkg::EVENT_OFF: begin
					ev_wr = st_ff.wstrb[0];
				end
				ptsp_pkg::STATUS_OFF: begin
					if (st_ff.wstrb[0] && st_ff.wdata[ptsp_pkg::STAT_ERR_BIT]) begin
						nxt_st.err = 1'b0;
					end
				end
				default: begin
				end
			endcase
		end
		if (s_axi_bready_i && st_ff.bvalid) begin
			nxt_st.bvalid = 1'b0;
		end

		// Register reads
		if (s_axi_rready_i && st_ff.rvalid) begin
			nxt_st.rvalid = 1'b0;
		end
		if (s_axi_arvalid_i && st_ff.arready) begin
			nxt_st.rvalid = 1'b1;
			case (rd_addr)
				ptsp_pkg::CTRL_OFF: nxt_st.rdata = ctrl_word;
				ptsp_pkg::DATA_OFF: nxt_st.rdata = st_ff.pend_data;
				ptsp_pkg::EVENT_OFF: nxt_st.rdata = {28'h000_0000, st_ff.pend_code};
				ptsp_pkg::STATUS_OFF: nxt_st.rdata = status_word;
				default: nxt_st.rdata = ptsp_pkg::RST_WORD;
			endcase
		end

		// Event queueing; reserved codes and writes while an event is still pending are refused
		rsvd_code = (new_code == ptsp_pkg::ST_RSVD2) || (new_code == ptsp_pkg::ST_RSVD6);
		if (ev_wr) begin
			if (rsvd_code || st_ff.pend) begin
				nxt_st.err = 1'b1;
			end else begin
				nxt_st.pend = 1'b1;
				nxt_st.pend_code = new_code;
			end
		end

		// Trace clock toggles every cycle; one trace cycle is two ref cycles
		nxt_st.pins.tclk = !st_ff.pins.tclk;
		nxt_st.pins.out_en = debug_mode_select_strap;

		if (trace_tick) begin
			byte_code = st_ff.pend_code[3:2] == 2'b10;
			long_code = st_ff.pend_code[3:2] == 2'b11;
			nxt_st.pins.nib_en = 1'b0;
			case (st_ff.fsm)
				ptsp_pkg::FSM_IDLE: begin
					nxt_st.pins.code = ptsp_pkg::ST_CONT;
					if (st_ff.pdown) begin
						nxt_st.pins.code = ptsp_pkg::ST_STOP;
						nxt_st.fsm = ptsp_pkg::FSM_PDOWN;
					end else if (st_ff.pend && st_ff.enable) begin
						// A write landing now saw pend set and was refused, so nothing stays queued
						nxt_st.pend = 1'b0;
						nxt_st.pins.code = st_ff.pend_code;
						nxt_st.shift = st_ff.pend_data;
						if (byte_code) begin
							// Two nibbles per announced byte
							nxt_st.dcnt = {1'b0, st_ff.pend_code[1:0], 1'b0} + 4'h2;
							nxt_st.fsm = ptsp_pkg::FSM_DATA;
						end else if (long_code) begin
							nxt_st.hold = ptsp_pkg::HOLD_CYCLES - 3'h1;
							nxt_st.fsm = ptsp_pkg::FSM_HOLD;
						end
					end
				end
				ptsp_pkg::FSM_DATA: begin
					nxt_st.pins.code = ptsp_pkg::ST_CONT;
					nxt_st.pins.nib = st_ff.shift[3:0];
					nxt_st.pins.nib_en = 1'b1;
					nxt_st.shift = {4'h0, st_ff.shift[31:4]};
					nxt_st.dcnt = st_ff.dcnt - 4'h1;
					if (st_ff.dcnt == 4'h1) begin
						nxt_st.fsm = ptsp_pkg::FSM_IDLE;
					end
				end
				ptsp_pkg::FSM_HOLD: begin
					nxt_st.hold = st_ff.hold - 3'h1;
					if (st_ff.hold == 3'h1) begin
						nxt_st.fsm = ptsp_pkg::FSM_IDLE;
					end
				end
				ptsp_pkg::FSM_PDOWN: begin
					nxt_st.pins.code = ptsp_pkg::ST_STOP;
					if (!wake_s) begin
						nxt_st.pdown = 1'b0;
						nxt_st.fsm = ptsp_pkg::FSM_IDLE;
					end
				end
				default: begin
					nxt_st.fsm = ptsp_pkg::FSM_IDLE;
				end
			endcase
		end

		// Reset pin: flush, release the data nibble, report reset exception
		if (!reset_in_s) begin
			nxt_st.pend = 1'b0;
			nxt_st.pdown = 1'b0;
			nxt_st.pins.nib_en = 1'b0;
			nxt_st.dcnt = 4'h0;
			if (trace_tick) begin
				nxt_st.pins.code = ptsp_pkg::ST_EXC;
				nxt_st.hold = ptsp_pkg::HOLD_CYCLES;
				nxt_st.fsm = ptsp_pkg::FSM_HOLD;
			end
		end

		nxt_st.awready = !nxt_st.aw_held && !nxt_st.bvalid;
		nxt_st.wready = !nxt_st.w_held && !nxt_st.bvalid;
		nxt_st.arready = !nxt_st.rvalid;
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st_ff <= '{fsm: ptsp_pkg::FSM_IDLE, default: '0};
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Float acts without the clock; scan enables win over it
	assign pad_ok = output_float_n_i;
	always_comb begin
		if (scan_active_i) begin
			trace_clock_oe_o = scan_oe_i;
			exec_state_oe_o = scan_oe_i;
			debug_nibble_oe_o = scan_oe_i;
		end else begin
			trace_clock_oe_o = st_ff.pins.out_en && pad_ok;
			exec_state_oe_o = st_ff.pins.out_en && pad_ok;
			debug_nibble_oe_o = st_ff.pins.out_en && st_ff.pins.nib_en && pad_ok;
		end
	end

	assign trace_clock_out_o = st_ff.pins.tclk;
	assign exec_state_bus_o = st_ff.pins.code;
	assign debug_nibble_bus_o = st_ff.pins.nib;
	assign s_axi_awready_o = st_ff.awready;
	assign s_axi_wready_o = st_ff.wready;
	assign s_axi_bvalid_o = st_ff.bvalid;
	assign s_axi_bresp_o = 2'b00;
	assign s_axi_arready_o = st_ff.arready;
	assign s_axi_rvalid_o = st_ff.rvalid;
	assign s_axi_rdata_o = st_ff.rdata;
	assign s_axi_rresp_o = 2'b00;
endmodule

// file: ptsp_pkg.sv
// Package holding constants, codes and types of the trace status port
package ptsp_pkg;
	localparam logic [7:0] CTRL_OFF = 8'h00;
	localparam logic [7:0] DATA_OFF = 8'h04;
	localparam logic [7:0] EVENT_OFF = 8'h08;
	localparam logic [7:0] STATUS_OFF = 8'h0C;
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_PDOWN_BIT = 1;
	localparam int STAT_PEND_BIT = 0;
	localparam int STAT_PDOWN_BIT = 1;
	localparam int STAT_ERR_BIT = 2;
	localparam int STAT_DBGMODE_BIT = 3;
	localparam int STAT_STRAPBAD_BIT = 4;
	localparam int STAT_CODE_LSB = 8;
	localparam logic [3:0] ST_CONT = 4'h0;
	localparam logic [3:0] ST_INSTR = 4'h1;
	localparam logic [3:0] ST_RSVD2 = 4'h2;
	localparam logic [3:0] ST_USER = 4'h3;
	localparam logic [3:0] ST_MARK = 4'h4;
	localparam logic [3:0] ST_BRANCH = 4'h5;
	localparam logic [3:0] ST_RSVD6 = 4'h6;
	localparam logic [3:0] ST_RET = 4'h7;
	localparam logic [3:0] ST_BYTE1 = 4'h8;
	localparam logic [3:0] ST_BYTE4 = 4'hB;
	localparam logic [3:0] ST_EXC = 4'hC;
	localparam logic [3:0] ST_EMU = 4'hD;
	localparam logic [3:0] ST_STOP = 4'hE;
	localparam logic [3:0] ST_HALT = 4'hF;
	localparam logic [2:0] HOLD_CYCLES = 3'h4;
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam int SYNC_W = 6;

	typedef enum logic [3:0] {
		FSM_IDLE = 4'b0001,
		FSM_DATA = 4'b0010,
		FSM_HOLD = 4'b0100,
		FSM_PDOWN = 4'b1000
	} ptsp_fsm_t;

	typedef struct packed {
		logic tclk;
		logic [3:0] code;
		logic [3:0] nib;
		logic nib_en;
		logic out_en;
	} ptsp_pins_t;

	typedef struct packed {
		ptsp_fsm_t fsm;
		ptsp_pins_t pins;
		logic [31:0] shift;
		logic [3:0] dcnt;
		logic [2:0] hold;
		logic pend;
		logic [3:0] pend_code;
		logic [31:0] pend_data;
		logic enable;
		logic pdown;
		logic err;
		logic aw_held;
		logic [7:0] awaddr;
		logic w_held;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic awready;
		logic wready;
		logic bvalid;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
	} ptsp_state_t;
endpackage

// file: ptsp_sync2.sv
// Two-stage synchroniser for pin inputs
module ptsp_sync2 #(
	parameter int W = 1
) (
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	input wire logic [W-1:0] async_i,
	input wire logic [W-1:0] rst_val_i,
	output logic [W-1:0] sync_o
);
	logic [W-1:0] meta_ff;
	logic [W-1:0] sync_ff;
	logic armed_ff;

	// Reset level taken from rst_val_i only after release, never under reset
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			meta_ff <= '0;
			sync_ff <= '0;
			armed_ff <= 1'b0;
		end else begin
			meta_ff <= async_i;
			armed_ff <= 1'b1;
			sync_ff <= armed_ff ? meta_ff : rst_val_i;
		end
	end

	assign sync_o = sync_ff;
endmodule

// file: ptsp_monitor.sv
// Pin-level checks on the trace status port
module ptsp_monitor (
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	input wire logic output_float_n_i,
	input wire logic scan_active_i,
	input wire logic scan_oe_i,
	input wire logic reset_in_n_i,
	input wire logic wake_n_i,
	input wire logic trace_clock_out_o,
	input wire logic trace_clock_oe_o,
	input wire logic [3:0] exec_state_bus_o,
	input wire logic exec_state_oe_o,
	input wire logic debug_nibble_oe_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge ref_clk_i);
	endclocking
	default disable iff (!rstn_i);
	sequence s_held;
		$changed(exec_state_bus_o) && exec_state_bus_o[3:2] == 2'b11;
	endsequence
	sequence s_bytes;
		$changed(exec_state_bus_o) && exec_state_bus_o[3:2] == 2'b10;
	endsequence
	property p_float;
		!output_float_n_i && !scan_active_i |->
			!(trace_clock_oe_o || exec_state_oe_o || debug_nibble_oe_o);
	endproperty
	property p_scan;
		scan_active_i |-> {trace_clock_oe_o, exec_state_oe_o, debug_nibble_oe_o} == {3{scan_oe_i}};
	endproperty
	// The first edge after release still shows the reset level
	property p_tclk;
		rstn_i |=> $changed(trace_clock_out_o);
	endproperty
	property p_fall;
		$changed(exec_state_bus_o) |-> $fell(trace_clock_out_o);
	endproperty
	property p_rsvd;
		exec_state_bus_o != ptsp_pkg::ST_RSVD2 && exec_state_bus_o != ptsp_pkg::ST_RSVD6;
	endproperty
	property p_hold;
		s_held |=> $stable(exec_state_bus_o)[*7];
	endproperty
	property p_nib;
		s_bytes |-> ##2 debug_nibble_oe_o[*4];
	endproperty
	property p_rstin;
		$fell(reset_in_n_i) |-> ##[1:8] (exec_state_bus_o == ptsp_pkg::ST_EXC && !debug_nibble_oe_o);
	endproperty
	property p_wake;
		exec_state_bus_o == ptsp_pkg::ST_STOP && !wake_n_i |-> ##[1:10]
			exec_state_bus_o != ptsp_pkg::ST_STOP;
	endproperty
	a_float: assert property (p_float) else $error("driver on while floated");
	a_scan: assert property (p_scan) else $error("scan enable ignored");
	a_tclk: assert property (p_tclk) else $error("trace clock stalled");
	a_fall: assert property (p_fall) else $error("status off trace timing");
	a_rsvd: assert property (p_rsvd) else $error("reserved status code");
	a_hold: assert property (p_hold) else $error("held code too short");
	a_nib: assert property (p_nib) else $error("nibbles missing");
	a_rstin: assert property (p_rstin) else $error("reset pin ignored");
	a_wake: assert property (p_wake) else $error("wake ignored");
endmodule

// file: ptsp_probe.sv
// Trace capture probe model on the status and nibble buses
module ptsp_probe (
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	input wire logic tclk_i,
	input wire logic oe_i,
	input wire logic [3:0] code_i,
	input wire logic nib_oe_i,
	input wire logic [3:0] nib_i,
	output logic [2:0] strap_o,
	output logic ev_o,
	output logic [4:0] ev_val_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] last_ff;
	assign strap_o = 3'h1;
	// One look per trace cycle, while the trace clock is low and the bus settled
	always @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			last_ff <= 4'h0;
			ev_o <= 1'b0;
			ev_val_o <= 5'h00;
		end else begin
			ev_o <= 1'b0;
			if (!tclk_i && oe_i) begin
				last_ff <= code_i;
				if (nib_oe_i) begin
					ev_o <= 1'b1;
					ev_val_o <= {1'b1, nib_i};
				end else if (code_i != last_ff && code_i != 4'h0) begin
					ev_o <= 1'b1;
					ev_val_o <= {1'b0, code_i};
				end
			end
		end
	end
endmodule

// file: testbench.sv
// Self-checking bench for the trace status port
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk_i = 1'b0, rstn_i = 1'b0;
	logic [31:0] s_axi_awaddr_i = '0, s_axi_wdata_i = '0, s_axi_araddr_i = '0, s_axi_rdata_o;
	logic [3:0] s_axi_wstrb_i = 4'hF;
	logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
	logic s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
	logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
	logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
	logic [2:0] test_mode_strap_i;
	logic output_float_n_i = 1'b1, scan_active_i = 1'b0, scan_oe_i = 1'b0;
	logic reset_in_n_i = 1'b1, wake_n_i = 1'b1;
	logic trace_clock_out_o, trace_clock_oe_o, exec_state_oe_o, debug_nibble_oe_o;
	logic [3:0] exec_state_bus_o, debug_nibble_bus_o;
	logic ev;
	logic [4:0] ev_val;
	logic [4:0] exp_q[$];
	logic [3:0] codes[8] = '{4'h1, 4'h3, 4'h4, 4'h5, 4'h7, 4'hC, 4'hD, 4'hF};
	int n_fail = 0, check_count = 0, seed = 32'h22f1_0133;
	logic [31:0] rv, d;
	always #4 ref_clk_i = ~ref_clk_i;
	ptsp_top i_dut (.ref_clk_i, .rstn_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o,
		.s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o,
		.s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o,
		.s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .test_mode_strap_i,
		.output_float_n_i, .scan_active_i, .scan_oe_i, .reset_in_n_i, .wake_n_i,
		.trace_clock_out_o, .trace_clock_oe_o, .exec_state_bus_o, .exec_state_oe_o,
		.debug_nibble_bus_o, .debug_nibble_oe_o);
	ptsp_probe i_probe (.ref_clk_i, .rstn_i, .tclk_i(trace_clock_out_o), .oe_i(exec_state_oe_o),
		.code_i(exec_state_bus_o), .nib_oe_i(debug_nibble_oe_o), .nib_i(debug_nibble_bus_o),
		.strap_o(test_mode_strap_i), .ev_o(ev), .ev_val_o(ev_val));
	task automatic end_sim;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			$display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
			n_fail++;
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		s_axi_awaddr_i <= {24'h00_0000, a};
		s_axi_wdata_i <= v;
		s_axi_awvalid_i <= 1'b1;
		s_axi_wvalid_i <= 1'b1;
		s_axi_bready_i <= 1'b1;
		do begin
			@(posedge ref_clk_i);
			if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
			if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
		end while (!s_axi_bvalid_o);
		chk(32'h0, 32'(s_axi_bresp_o));
		s_axi_bready_i <= 1'b0;
		@(posedge ref_clk_i);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		s_axi_araddr_i <= {24'h00_0000, a};
		s_axi_arvalid_i <= 1'b1;
		s_axi_rready_i <= 1'b1;
		do begin
			@(posedge ref_clk_i);
			if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
		end while (!s_axi_rvalid_o);
		v = s_axi_rdata_o;
		chk(32'h0, 32'(s_axi_rresp_o));
		s_axi_rready_i <= 1'b0;
		@(posedge ref_clk_i);
	endtask
	// Queue the code and its nibbles, then wait until the probe has shown them all
	task automatic ev_go(input logic [3:0] c, input int n);
		exp_q.push_back({1'b0, c});
		for (int i = 0; i < n; i++) exp_q.push_back({1'b1, d[4*i +: 4]});
		wr(ptsp_pkg::EVENT_OFF, {28'h000_0000, c});
		while (exp_q.size() != 0) @(posedge ref_clk_i);
		repeat (24) @(posedge ref_clk_i);
	endtask
	always @(posedge ref_clk_i) begin
		if (ev) chk(exp_q.size() ? exp_q.pop_front() : 5'h00, ev_val);
	end
	initial begin
		repeat (8) @(posedge ref_clk_i);
		rstn_i <= 1'b1;
		repeat (4) @(posedge ref_clk_i);
		rd(ptsp_pkg::STATUS_OFF, rv);
		chk(32'h0000_0008, rv);
		rd(8'h40, rv);
		chk(32'h0000_0000, rv);
		$display("registers done");
		wr(ptsp_pkg::EVENT_OFF, 32'h0000_0001);
		wr(ptsp_pkg::EVENT_OFF, 32'h0000_0003);
		rd(ptsp_pkg::STATUS_OFF, rv);
		chk(32'h0000_000D, rv);
		exp_q.push_back({1'b0, ptsp_pkg::ST_INSTR});
		wr(ptsp_pkg::CTRL_OFF, 32'h0000_0001);
		wr(ptsp_pkg::STATUS_OFF, 32'h0000_0004);
		rd(ptsp_pkg::STATUS_OFF, rv);
		chk(32'h0000_0008, rv);
		foreach (codes[i]) ev_go(codes[i], 0);
		for (int k = 0; k < 4; k++) begin
			d = $random(seed);
			wr(ptsp_pkg::DATA_OFF, d);
			ev_go(ptsp_pkg::ST_BYTE1 + 4'(k), 2 * (k + 1));
		end
		$display("codes done");
		for (int i = 0; i < 2; i++) begin
			wr(ptsp_pkg::EVENT_OFF, {28'h000_0000, i ? ptsp_pkg::ST_RSVD6 : ptsp_pkg::ST_RSVD2});
			rd(ptsp_pkg::STATUS_OFF, rv);
			chk(32'h1, rv[ptsp_pkg::STAT_ERR_BIT]);
			wr(ptsp_pkg::STATUS_OFF, 32'h0000_0004);
			rd(ptsp_pkg::STATUS_OFF, rv);
			chk(32'h0, rv[ptsp_pkg::STAT_ERR_BIT]);
		end
		$display("reserved done");
		exp_q.push_back({1'b0, ptsp_pkg::ST_STOP});
		wr(ptsp_pkg::CTRL_OFF, 32'h0000_0003);
		repeat (40) @(posedge ref_clk_i);
		rd(ptsp_pkg::STATUS_OFF, rv);
		chk(32'h1, rv[ptsp_pkg::STAT_PDOWN_BIT]);
		wake_n_i <= 1'b0;
		repeat (16) @(posedge ref_clk_i);
		wake_n_i <= 1'b1;
		rd(ptsp_pkg::STATUS_OFF, rv);
		chk(32'h0, rv[ptsp_pkg::STAT_PDOWN_BIT]);
		$display("power-down done");
		exp_q.push_back({1'b0, ptsp_pkg::ST_EXC});
		reset_in_n_i <= 1'b0;
		repeat (12) @(posedge ref_clk_i);
		reset_in_n_i <= 1'b1;
		repeat (40) @(posedge ref_clk_i);
		chk(32'h0, exp_q.size());
		$display("reset pin done");
		output_float_n_i <= 1'b0;
		@(negedge ref_clk_i);
		chk(32'h0, {trace_clock_oe_o, exec_state_oe_o, debug_nibble_oe_o});
		@(posedge ref_clk_i);
		scan_active_i <= 1'b1;
		scan_oe_i <= 1'b1;
		@(negedge ref_clk_i);
		chk(32'h7, {trace_clock_oe_o, exec_state_oe_o, debug_nibble_oe_o});
		repeat (2) @(posedge ref_clk_i);
		$display("float done");
		end_sim;
	end
	initial begin
		#100000;
		n_fail++;
		end_sim;
	end
endmodule
bind ptsp_top ptsp_monitor u_mon (.ref_clk_i, .rstn_i, .output_float_n_i, .scan_active_i,
	.scan_oe_i, .reset_in_n_i, .wake_n_i, .trace_clock_out_o, .trace_clock_oe_o,
	.exec_state_bus_o, .exec_state_oe_o, .debug_nibble_oe_o);
